//--- atu_tlb.sv
// Purpose: Shared constants and types, plus one translation buffer.
// Assumes: One clock, synchronous active-low reset.
// Notes: Lookup is combinational; the caller registers what it shows.

`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Shared definitions
// ----------------------------------------------------------------------
package atu_pkg;
  // Coprocessor register numbers.
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_TBASE = 4'h2;
  localparam logic [3:0] REG_DACR = 4'h3;
  localparam logic [3:0] REG_FSR = 4'h5;
  localparam logic [3:0] REG_FAR = 4'h6;
  localparam logic [3:0] REG_TLBOP = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hf;
  // Field positions.
  localparam int CTRL_EN = 0;
  localparam int STAT_DMODE = 3;
  localparam int STAT_IMODE = 2;
  localparam int TBASE_LSB = 14;
  localparam logic [13:0] TBASE_ZERO = 14'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Level-1 descriptor types.
  localparam logic [1:0] L1_FAULT = 2'h0;
  localparam logic [1:0] L1_COARSE = 2'h1;
  localparam logic [1:0] L1_SECT = 2'h2;
  localparam logic [1:0] L1_FINE = 2'h3;
  // Level-2 descriptor types.
  localparam logic [1:0] L2_FAULT = 2'h0;
  localparam logic [1:0] L2_LARGE = 2'h1;
  localparam logic [1:0] L2_SMALL = 2'h2;
  // Domain access codes.
  localparam logic [1:0] DOM_CLIENT = 2'h1;
  localparam logic [1:0] DOM_MANAGER = 2'h3;
  // Access permission codes.
  localparam logic [1:0] AP_PRIV = 2'h1;
  localparam logic [1:0] AP_USER_RO = 2'h2;
  localparam logic [1:0] AP_ALL = 2'h3;
  // Fault status codes.
  localparam logic [3:0] FS_SECT_XLAT = 4'h5;
  localparam logic [3:0] FS_PAGE_XLAT = 4'h7;
  localparam logic [3:0] FS_SECT_DOM = 4'h9;
  localparam logic [3:0] FS_PAGE_DOM = 4'hb;
  localparam logic [3:0] FS_SECT_PERM = 4'hd;
  localparam logic [3:0] FS_PAGE_PERM = 4'hf;
  // Tag masks over address bits 31..10 for each mapping size.
  localparam logic [21:0] MASK_SECT = 22'h3ffc00;
  localparam logic [21:0] MASK_LARGE = 22'h3fffc0;
  localparam logic [21:0] MASK_SMALL = 22'h3ffffc;
  localparam logic [21:0] MASK_TINY = 22'h3fffff;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  typedef enum logic [1:0] {SZ_SECT, SZ_LARGE, SZ_SMALL, SZ_TINY} atu_size_t;

  typedef struct packed {
    logic valid;
    logic [21:0] tag;
    atu_size_t size;
    logic [21:0] pbase;
    logic [3:0] dom;
    logic [7:0] ap;
  } atu_entry_t;

  typedef struct packed {
    logic [31:0] va;
    logic wr;
    logic priv;
  } atu_req_t;

  function automatic logic [21:0] atu_mask(input atu_size_t s);
    unique case (s)
      SZ_SECT: atu_mask = MASK_SECT;
      SZ_LARGE: atu_mask = MASK_LARGE;
      SZ_SMALL: atu_mask = MASK_SMALL;
      SZ_TINY: atu_mask = MASK_TINY;
    endcase
  endfunction : atu_mask
endpackage : atu_pkg

// ----------------------------------------------------------------------
// Translation buffer
// ----------------------------------------------------------------------
module atu_tlb import atu_pkg::*; #(
  parameter int ENTRIES = 64
) (
  input wire logic clk, // Processor clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic [31:0] look_va, // Address being looked up.
  output logic hit, // Some valid entry covers look_va.
  output atu_entry_t hit_entry, // The covering entry.
  input wire logic fill, // Install fill_entry this cycle.
  input wire atu_entry_t fill_entry, // Entry from the table walk.
  input wire logic flush, // Invalidate every entry.
  input wire logic random_mode // Victim choice: 1 random, 0 in turn.
);
  localparam int IW = $clog2(ENTRIES);

  if (ENTRIES < 2 || ENTRIES > 65536 || (1 << IW) != ENTRIES) begin : g_chk
    $error("atu_tlb: ENTRIES must be a power of two from 2 to 65536");
  end

  atu_entry_t entries [ENTRIES];
  logic [ENTRIES-1:0] match;
  logic [IW-1:0] seq_ptr;
  logic [15:0] lfsr;
  logic [IW-1:0] victim;

  // Per-entry compare against the address masked to the entry's size.
  for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
    assign match[i] = entries[i].valid && (entries[i].tag ==
      (look_va[31:10] & atu_mask(entries[i].size)));
  end

  // Overlapping entries OR together, which is why software must flush.
  always_comb begin
    hit_entry = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (match[i]) begin
        hit_entry = hit_entry | entries[i];
      end
    end
  end
  assign hit = |match;

  // Random mode takes free-running pseudo-random bits; sequential mode
  // walks a pointer that wraps from the last entry to the first.
  assign victim = random_mode ? lfsr[IW-1:0] : seq_ptr;

  // Storage, victim pointer and random source.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < ENTRIES; i++) begin
        entries[i] <= '0;
      end
      seq_ptr <= '0;
      lfsr <= LFSR_SEED;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      if (flush) begin
        for (int i = 0; i < ENTRIES; i++) begin
          entries[i].valid <= 1'b0;
        end
      end
      if (fill) begin
        entries[victim] <= fill_entry;
        seq_ptr <= seq_ptr + 1'b1;
      end
    end
  end

  property p_seq_step;
    @(posedge clk) disable iff (!rst_b)
      fill && !random_mode |=> seq_ptr == $past(seq_ptr) + 1'b1;
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("sequential victim pointer did not advance by one");
endmodule : atu_tlb

//--- atu_top.sv
// Purpose: Address translation unit with instruction and data buffers.
// Assumes: Core, memory bus and companion port share REF_CLK.
// Notes: One table walker serves both sides; data wins a tie.

`timescale 1ns/1ps

// Function
// - Two 64-entry translation buffers, one for fetches, one for data.
// - Sections map 1 MB blocks with one buffer entry.
// - Large 64 KB, small 4 KB and tiny 1 KB pages are supported.
// - On a hit, check permission and drive the physical address.
// - A rejected access returns abort instead of an address.
// - On a miss, walk the table and fill an entry chosen randomly or in turn, per the side's mode bit.
// - Each address of a multiple transfer is checked on its own.
// - Sixteen domains, one shared domain access register.
// - When disabled, addresses pass untranslated and unchecked.
// - Small pages have 1 KB subpages, large pages 16 KB subpages.
// - Tiny pages and sections use one permission for the block.
// - Registers hold state and are read/write, except register 8.
// - A data abort updates fault status and fault address.
// - Walks fetch level one; pages need a level-two fetch too.
// - Table base low 14 bits are forced to zero.
// - First-level table holds 4096 word entries of 1 MB each.
// - Level-one address is base 31..14 joined to address 31..20.
// - Status bits 3 and 2 show data/instruction replacement mode.
// - Companion processor shared accesses pass without translation.
// - Level-one type: 00 fault, 01 coarse, 10 section, 11 fine.
// - A page table descriptor starts a level-two fetch from its base.
// - Section physical base comes from descriptor bits 31..20.
// - Section permission is checked before the address is driven.
module atu_top import atu_pkg::*; #(
  parameter int ENTRIES = 64
) (
  input wire logic REF_CLK, // Processor clock, 10 MHz.
  input wire logic RST_B, // Synchronous reset, active low.
  input wire logic CP_WR, // Coprocessor register write strobe.
  input wire logic CP_RD, // Coprocessor register read strobe.
  input wire logic [3:0] CP_REG, // Coprocessor register number.
  input wire logic [31:0] CP_WDATA, // Write data.
  output logic [31:0] CP_RDATA, // Read data, valid after CP_RD.
  input wire logic I_VALID, // Fetch request, held until I_ACK.
  input wire atu_req_t I_REQ, // Fetch address and mode.
  output logic I_ACK, // Fetch answered, one cycle.
  output logic [31:0] I_PA, // Fetch physical address.
  output logic I_ABORT, // Fetch aborted.
  input wire logic D_VALID, // Data request, held until D_ACK.
  input wire atu_req_t D_REQ, // Data address, direction and mode.
  output logic D_ACK, // Data answered, one cycle.
  output logic [31:0] D_PA, // Data physical address.
  output logic D_ABORT, // Data aborted.
  output logic M_REQ, // Table fetch request, held until M_ACK.
  output logic [31:0] M_ADDR, // Table fetch byte address.
  input wire logic M_ACK, // Table fetch done.
  input wire logic [31:0] M_RDATA, // Fetched descriptor.
  input wire logic DSP_VALID, // Companion shared access.
  input wire logic [31:0] DSP_ADDR, // Companion address.
  output logic SH_VALID, // Shared access forwarded.
  output logic [31:0] SH_ADDR // Shared address, untranslated.
);
  typedef enum logic [1:0] {WK_IDLE, WK_L1, WK_L2} atu_walk_t;

  if (ENTRIES < 2) begin : g_chk
    $error("atu_top: ENTRIES must be at least 2");
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] tbase;
  logic [31:0] dacr;
  logic [7:0] fsr;
  logic [31:0] far_q;
  logic imode;
  logic dmode;
  logic en;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;
  logic flush;

  assign en = ctrl[CTRL_EN];
  assign flush = CP_WR && (CP_REG == REG_TLBOP);
  assign stat_word = {28'h0000000, dmode, imode, 2'h0};
  assign rd_mux = (CP_REG == REG_CTRL) ? ctrl :
                  (CP_REG == REG_TBASE) ? tbase :
                  (CP_REG == REG_DACR) ? dacr :
                  (CP_REG == REG_FSR) ? {24'h000000, fsr} :
                  (CP_REG == REG_FAR) ? far_q :
                  (CP_REG == REG_STAT) ? stat_word : RST_WORD;

  // ----------------------------------------------------------------------
  // Per-side lookup and answer
  // ----------------------------------------------------------------------
  logic [1:0] req_v;
  atu_req_t req [2];
  logic [1:0] hit;
  atu_entry_t ent [2];
  logic [1:0] fill;
  logic [1:0] busy;
  logic [1:0] wk_fault;
  logic [1:0] ack_q;
  logic [1:0] abort_q;
  logic [31:0] pa_q [2];
  logic [1:0] perm_ok;
  logic [3:0] hit_code [2];
  logic [1:0] mode;

  atu_walk_t state;
  logic wside;
  logic [31:0] wva;
  logic [31:0] l1d;
  atu_entry_t fill_ent;
  logic fill_c;
  logic [3:0] wk_code;

  assign req_v = {D_VALID, I_VALID};
  assign req[0] = I_REQ;
  assign req[1] = D_REQ;
  assign mode = {dmode, imode};

  for (genvar s = 0; s < 2; s++) begin : g_side
    logic [21:0] msk;
    logic [1:0] idx;
    logic [1:0] ap;
    logic [1:0] dacc;
    logic ap_ok;
    logic is_sect;
    logic go;
    logic [31:0] pa_c;

    atu_tlb #(.ENTRIES(ENTRIES)) u_tlb (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .look_va(req[s].va),
      .hit(hit[s]),
      .hit_entry(ent[s]),
      .fill(fill[s]),
      .fill_entry(fill_ent),
      .flush(flush),
      .random_mode(mode[s])
    );

    // Subpage select: large pages by bits 15..14, small by 11..10.
    assign msk = atu_mask(ent[s].size);
    assign idx = (ent[s].size == SZ_LARGE) ? req[s].va[15:14] :
                 (ent[s].size == SZ_SMALL) ? req[s].va[11:10] :
                 2'h0;
    assign ap = ent[s].ap[2*idx +: 2];
    assign dacc = dacr[2*ent[s].dom +: 2];
    assign ap_ok = (ap == AP_ALL) || ((ap == AP_USER_RO) &&
                   (req[s].priv || !req[s].wr)) ||
                   ((ap == AP_PRIV) && req[s].priv);
    assign perm_ok[s] = (dacc == DOM_MANAGER) ||
                        ((dacc == DOM_CLIENT) && ap_ok);
    assign is_sect = ent[s].size == SZ_SECT;
    assign hit_code[s] = (dacc != DOM_MANAGER && dacc != DOM_CLIENT) ?
      (is_sect ? FS_SECT_DOM : FS_PAGE_DOM) :
      (is_sect ? FS_SECT_PERM : FS_PAGE_PERM);
    assign pa_c = {(ent[s].pbase & msk) | (req[s].va[31:10] & ~msk),
                   req[s].va[9:0]};
    assign busy[s] = (state != WK_IDLE) && (wside == s);
    // Each request is checked afresh, so burst addresses each see a check.
    assign go = req_v[s] && !ack_q[s] && !busy[s];

    // The answer flops; a walk fault answers with abort directly.
    always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
        ack_q[s] <= 1'b0;
        abort_q[s] <= 1'b0;
        pa_q[s] <= RST_WORD;
      end else begin
        ack_q[s] <= wk_fault[s] || (go && (!en || hit[s]));
        abort_q[s] <= wk_fault[s] ||
                      (go && en && hit[s] && !perm_ok[s]);
        if (go && !en) begin
          pa_q[s] <= req[s].va;
        end else if (go && hit[s] && perm_ok[s]) begin
          pa_q[s] <= pa_c;
        end
      end
    end
  end

  assign I_ACK = ack_q[0];
  assign I_ABORT = abort_q[0];
  assign I_PA = pa_q[0];
  assign D_ACK = ack_q[1];
  assign D_ABORT = abort_q[1];
  assign D_PA = pa_q[1];

  // ----------------------------------------------------------------------
  // Table walker
  // ----------------------------------------------------------------------
  logic [1:0] miss;
  logic start;
  logic start_side;
  logic [31:0] l1_addr;
  logic [31:0] l2_addr;
  logic l1_page;
  atu_size_t l2_size;

  assign miss = req_v & ~ack_q & ~hit & {2{en}};
  assign start = (state == WK_IDLE) && (|miss);
  assign start_side = miss[1]; // Data first.
  assign l1_addr = {tbase[31:TBASE_LSB], req[start_side].va[31:20],
                    2'h0};
  assign l1_page = (M_RDATA[1:0] == L1_COARSE) ||
                   (M_RDATA[1:0] == L1_FINE);
  assign l2_addr = (M_RDATA[1:0] == L1_COARSE) ?
                   {M_RDATA[31:10], wva[19:12], 2'h0} :
                   {M_RDATA[31:12], wva[19:10], 2'h0};
  assign l2_size = (M_RDATA[1:0] == L2_LARGE) ? SZ_LARGE :
                   (M_RDATA[1:0] == L2_SMALL) ? SZ_SMALL : SZ_TINY;

  // Level-one completion fills sections; level two fills pages.
  always_comb begin
    fill_ent = '0;
    fill_c = 1'b0;
    wk_code = FS_SECT_XLAT;
    if (state == WK_L1 && M_ACK && M_RDATA[1:0] == L1_SECT) begin
      fill_c = 1'b1;
      fill_ent.valid = 1'b1;
      fill_ent.size = SZ_SECT;
      fill_ent.tag = wva[31:10] & MASK_SECT;
      fill_ent.pbase = {M_RDATA[31:20], 10'h000};
      fill_ent.dom = M_RDATA[8:5];
      fill_ent.ap = {4{M_RDATA[11:10]}};
    end else if (state == WK_L2 && M_ACK && M_RDATA[1:0] != L2_FAULT) begin
      fill_c = 1'b1;
      fill_ent.valid = 1'b1;
      fill_ent.size = l2_size;
      fill_ent.tag = wva[31:10] & atu_mask(l2_size);
      fill_ent.pbase = M_RDATA[31:10];
      fill_ent.dom = l1d[8:5];
      fill_ent.ap = M_RDATA[11:4];
    end else if (state == WK_L2) begin
      wk_code = FS_PAGE_XLAT;
    end
  end

  assign fill = {fill_c && wside, fill_c && !wside};
  assign wk_fault = {2{M_ACK && (((state == WK_L1) &&
                    (M_RDATA[1:0] == L1_FAULT)) || ((state == WK_L2) &&
                    (M_RDATA[1:0] == L2_FAULT)))}} &
                    {wside, !wside};

  // Walk sequencing and the table fetch port.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      state <= WK_IDLE;
      wside <= 1'b0;
      wva <= RST_WORD;
      l1d <= RST_WORD;
      M_REQ <= 1'b0;
      M_ADDR <= RST_WORD;
    end else begin
      unique case (state)
        WK_IDLE: if (start) begin
          state <= WK_L1;
          wside <= start_side;
          wva <= req[start_side].va;
          M_REQ <= 1'b1;
          M_ADDR <= l1_addr;
        end
        WK_L1: if (M_ACK) begin
          l1d <= M_RDATA;
          if (l1_page) begin
            state <= WK_L2;
            M_ADDR <= l2_addr;
          end else begin
            state <= WK_IDLE;
            M_REQ <= 1'b0;
          end
        end
        WK_L2: if (M_ACK) begin
          state <= WK_IDLE;
          M_REQ <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register writes, reads and companion pass-through
  // ----------------------------------------------------------------------
  // Hardware fault capture beats a software write in the same cycle.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      ctrl <= RST_WORD;
      tbase <= RST_WORD;
      dacr <= RST_WORD;
      fsr <= 8'h00;
      far_q <= RST_WORD;
      imode <= 1'b0;
      dmode <= 1'b0;
      CP_RDATA <= RST_WORD;
      SH_VALID <= 1'b0;
      SH_ADDR <= RST_WORD;
    end else begin
      if (CP_WR && CP_REG == REG_CTRL) ctrl <= CP_WDATA;
      if (CP_WR && CP_REG == REG_TBASE) tbase <= {CP_WDATA[31:TBASE_LSB],
                                                 TBASE_ZERO};
      if (CP_WR && CP_REG == REG_DACR) dacr <= CP_WDATA;
      if (CP_WR && CP_REG == REG_STAT) begin
        dmode <= CP_WDATA[STAT_DMODE];
        imode <= CP_WDATA[STAT_IMODE];
      end
      if (wk_fault[1]) begin
        fsr <= {l1d[8:5], wk_code};
        far_q <= wva;
      end else if (g_side[1].go && en && hit[1] && !perm_ok[1]) begin
        fsr <= {ent[1].dom, hit_code[1]};
        far_q <= req[1].va;
      end else begin
        if (CP_WR && CP_REG == REG_FSR) fsr <= CP_WDATA[7:0];
        if (CP_WR && CP_REG == REG_FAR) far_q <= CP_WDATA;
      end
      if (CP_RD) CP_RDATA <= rd_mux;
      SH_VALID <= DSP_VALID;
      SH_ADDR <= DSP_ADDR;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_tbase_low;
    @(posedge REF_CLK) disable iff (!RST_B)
      tbase[TBASE_LSB-1:0] == TBASE_ZERO;
  endproperty
  a_tbase_low: assert property (p_tbase_low)
    else $error("table base low bits not zero");

  property p_l1_addr;
    @(posedge REF_CLK) disable iff (!RST_B)
      start |=> M_REQ && M_ADDR == {tbase[31:TBASE_LSB], wva[31:20], 2'h0};
  endproperty
  a_l1_addr: assert property (p_l1_addr)
    else $error("level-one address malformed");

  property p_bypass;
    @(posedge REF_CLK) disable iff (!RST_B)
      !en && I_VALID && !I_ACK && !busy[0] |=>
        I_ACK && !I_ABORT && I_PA == $past(I_REQ.va);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("disabled unit altered or refused an access");

  property p_abort_fsr;
    @(posedge REF_CLK) disable iff (!RST_B)
      D_ACK && D_ABORT |-> fsr[3:0] != 4'h0 && fsr[0];
  endproperty
  a_abort_fsr: assert property (p_abort_fsr)
    else $error("data abort without fault status");

  property p_stall;
    @(posedge REF_CLK) disable iff (!RST_B)
      busy[1] && !wk_fault[1] |=> !D_ACK;
  endproperty
  a_stall: assert property (p_stall)
    else $error("data access answered during its walk");

  property p_sect_done;
    @(posedge REF_CLK) disable iff (!RST_B)
      state == WK_L1 && M_ACK && M_RDATA[1:0] == L1_SECT |->
        fill_c ##1 state == WK_IDLE && !M_REQ;
  endproperty
  a_sect_done: assert property (p_sect_done)
    else $error("section walk did not end after level one");

  property p_l2_start;
    @(posedge REF_CLK) disable iff (!RST_B)
      state == WK_L1 && M_ACK && l1_page |=>
        state == WK_L2 && M_REQ && M_ADDR[1:0] == 2'h0;
  endproperty
  a_l2_start: assert property (p_l2_start)
    else $error("page descriptor did not start level two");

  property p_shared;
    @(posedge REF_CLK) disable iff (!RST_B)
      DSP_VALID |=> SH_VALID && SH_ADDR == $past(DSP_ADDR);
  endproperty
  a_shared: assert property (p_shared)
    else $error("shared access was altered");

  property p_mode_reset;
    @(posedge REF_CLK) !RST_B |=> !imode && !dmode;
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("replacement modes not cleared by reset");
endmodule : atu_top

//--- atu_mem_model.sv
// Purpose: Behavioural memory that answers table fetches.
// Assumes: Fetches are sampled on the rising edge of the processor clock.
// Notes: Unwritten words read as zero, which is a fault descriptor.

`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Table memory
// ----------------------------------------------------------------------
module atu_mem_model (
  input wire logic clk, // Processor clock.
  input wire logic [7:0] lat, // Wait cycles before each answer.
  input wire logic req, // Table fetch request.
  input wire logic [31:0] addr, // Table fetch byte address.
  output logic ack, // Answer strobe, one cycle.
  output logic [31:0] rdata // Descriptor, meaningful with ack only.
);
  logic [31:0] mem [logic [31:0]];
  logic [7:0] waited = 8'h00;

  initial begin
    ack = 1'b0;
    rdata = 32'h0;
  end

  // Lets the bench place descriptors before a walk.
  task automatic put(input logic [31:0] a, input logic [31:0] d);
    mem[a] = d;
  endtask : put

  // Data toggles outside answers so a stale word can never pass as good.
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (req === 1'b1 && ack !== 1'b1) begin
      if (waited >= lat) begin
        ack <= 1'b1;
        waited <= 8'h00;
        rdata <= mem.exists(addr) ? mem[addr] : 32'h0;
      end else begin
        waited <= waited + 8'h01;
      end
    end
  end
endmodule : atu_mem_model

//--- atu_top_test.sv
// Purpose: Self-checking bench for the address translation unit.
// Assumes: Inputs change 10 ns after each rising edge.
// Notes: Four buffer entries keep the walks short.

`timescale 1ns/1ps

module atu_top_test import atu_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cp_wr = 1'b0;
  logic cp_rd = 1'b0;
  logic [3:0] cp_reg = 4'h0;
  logic [31:0] cp_wdata = 32'h0;
  logic [31:0] dsp_addr = 32'h0;
  logic i_valid = 1'b0;
  logic d_valid = 1'b0;
  logic dsp_valid = 1'b0;
  atu_req_t i_req = '0;
  atu_req_t d_req = '0;
  logic [7:0] lat = 8'h00;
  logic [31:0] cp_rdata, i_pa, d_pa, m_addr, m_rdata, sh_addr, pa, l1, v;
  logic i_ack, i_abort, d_ack, d_abort, m_req, m_ack, sh_valid, ab;
  int fetches = 0;
  int cycles = 0;
  int failures = 0;
  int total_checks = 0;

  always #50 ref_clk = ~ref_clk;

  atu_top #(.ENTRIES(4)) u_atu_top (.REF_CLK(ref_clk), .RST_B(rst_b),
    .CP_WR(cp_wr), .CP_RD(cp_rd), .CP_REG(cp_reg), .CP_WDATA(cp_wdata),
    .CP_RDATA(cp_rdata), .I_VALID(i_valid), .I_REQ(i_req), .I_ACK(i_ack),
    .I_PA(i_pa), .I_ABORT(i_abort), .D_VALID(d_valid), .D_REQ(d_req),
    .D_ACK(d_ack), .D_PA(d_pa), .D_ABORT(d_abort), .M_REQ(m_req),
    .M_ADDR(m_addr), .M_ACK(m_ack), .M_RDATA(m_rdata),
    .DSP_VALID(dsp_valid), .DSP_ADDR(dsp_addr), .SH_VALID(sh_valid),
    .SH_ADDR(sh_addr));

  atu_mem_model u_atu_mem_model (.clk(ref_clk), .lat(lat), .req(m_req),
    .addr(m_addr), .ack(m_ack), .rdata(m_rdata));

  // Counts answered table fetches and cuts a hung run short.
  always @(posedge ref_clk) begin
    if (m_req === 1'b1 && m_ack === 1'b1) fetches++;
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // An edge passes after each strobe so back-to-back calls never collide.
  task automatic cp_write(input logic [3:0] r, input logic [31:0] d);
    cp_reg = r;
    cp_wdata = d;
    cp_wr = 1'b1;
    @(posedge ref_clk) #10;
    cp_wr = 1'b0;
    @(posedge ref_clk) #10;
  endtask : cp_write

  task automatic cp_read(input logic [3:0] r, output logic [31:0] d);
    cp_reg = r;
    cp_rd = 1'b1;
    @(posedge ref_clk) #10;
    cp_rd = 1'b0;
    d = cp_rdata;
    @(posedge ref_clk) #10;
  endtask : cp_read

  // One core access, held until acknowledged; notes the first fetch address.
  task automatic xfer(input logic is_d, input logic [31:0] va,
    input logic pv);
    int n;
    n = 0;
    fetches = 0;
    l1 = 32'h0;
    if (is_d) d_req = {va, 1'b0, pv};
    else i_req = {va, 1'b0, pv};
    if (is_d) d_valid = 1'b1;
    else i_valid = 1'b1;
    while (n < 60 && (is_d ? d_ack : i_ack) !== 1'b1) begin
      @(posedge ref_clk) #10;
      n++;
      if (m_req === 1'b1 && l1 === 32'h0) l1 = m_addr;
    end
    d_valid = 1'b0;
    i_valid = 1'b0;
    pa = is_d ? d_pa : i_pa;
    ab = is_d ? d_abort : i_abort;
    chk("ack", {31'h0, n < 60}, 32'h1);
    @(posedge ref_clk) #10;
  endtask : xfer

  task automatic t_regs();
    logic [3:0] regs [6] = '{REG_CTRL, REG_TBASE, REG_DACR, REG_STAT,
      REG_TLBOP, 4'h9};
    foreach (regs[k]) begin
      cp_read(regs[k], v);
      chk("reset word", v, RST_WORD);
    end
    cp_write(REG_TBASE, 32'hffff_ffff);
    cp_read(REG_TBASE, v);
    chk("table base", v, {18'h3ffff, TBASE_ZERO});
    cp_write(REG_STAT, 32'h0000_000c);
    cp_read(REG_STAT, v);
    chk("mode bits", v & 32'hc, 32'hc);
    cp_write(REG_STAT, 32'h0);
    cp_write(4'h9, 32'hffff_ffff);
    cp_read(4'h9, v);
    chk("unmapped", v, 32'h0);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_off();
    xfer(1'b1, 32'h8765_4321, 1'b1);
    chk("off pa", pa, 32'h8765_4321);
    chk("off abort", {31'h0, ab}, 32'h0);
    xfer(1'b0, 32'h1357_9bdf, 1'b0);
    chk("off ipa", pa, 32'h1357_9bdf);
    chk("off fetch", fetches, 32'h0);
    dsp_valid = 1'b1;
    dsp_addr = 32'hdead_beef;
    @(posedge ref_clk) #10;
    dsp_valid = 1'b0;
    chk("sh valid", {31'h0, sh_valid}, 32'h1);
    chk("sh addr", sh_addr, 32'hdead_beef);
    $display("t_off done");
  endtask : t_off

  task automatic t_sect();
    cp_write(REG_TBASE, 32'h0000_7fff);
    cp_write(REG_DACR, {30'h0, DOM_CLIENT});
    cp_write(REG_CTRL, 32'h1);
    u_atu_mem_model.put(32'h0000_4010, 32'h1230_0c12);
    lat = 8'h03;
    xfer(1'b1, 32'h0045_6789, 1'b1);
    chk("l1 addr", l1, 32'h0000_4010);
    chk("sect pa", pa, 32'h1235_6789);
    chk("sect fetch", fetches, 32'h1);
    xfer(1'b1, 32'h0045_0000, 1'b0);
    chk("hit pa", pa, 32'h1235_0000);
    chk("hit fetch", fetches, 32'h0);
    xfer(1'b0, 32'h0045_6789, 1'b1);
    chk("i fetch", fetches, 32'h1);
    chk("i pa", pa, 32'h1235_6789);
    chk("i abort", {31'h0, ab}, 32'h0);
    lat = 8'h00;
    $display("t_sect done");
  endtask : t_sect

  task automatic t_fault();
    xfer(1'b1, 32'h0070_0004, 1'b1);
    chk("fault abort", {31'h0, ab}, 32'h1);
    cp_read(REG_FSR, v);
    chk("fault code", v & 32'hf, {28'h0, FS_SECT_XLAT});
    cp_read(REG_FAR, v);
    chk("fault addr", v, 32'h0070_0004);
    $display("t_fault done");
  endtask : t_fault

  task automatic t_page();
    u_atu_mem_model.put(32'h0000_4020, 32'h0002_0011);
    u_atu_mem_model.put(32'h0002_000c, 32'h5555_53f2);
    xfer(1'b1, 32'h0080_3004, 1'b1);
    chk("page pa", pa, 32'h5555_5004);
    chk("page fetch", fetches, 32'h2);
    xfer(1'b1, 32'h0080_3c08, 1'b0);
    chk("sub abort", {31'h0, ab}, 32'h1);
    chk("sub fetch", fetches, 32'h0);
    cp_read(REG_FSR, v);
    chk("perm code", v & 32'hf, {28'h0, FS_PAGE_PERM});
    $display("t_page done");
  endtask : t_page

  task automatic t_flush();
    cp_write(REG_STAT, 32'h0000_0008);
    cp_write(REG_TLBOP, 32'h0);
    xfer(1'b1, 32'h0045_6789, 1'b1);
    chk("flush fetch", fetches, 32'h1);
    chk("flush pa", pa, 32'h1235_6789);
    $display("t_flush done");
  endtask : t_flush

  // Reset for three edges, then the scenarios in order.
  initial begin
    repeat (3) @(posedge ref_clk);
    #10;
    rst_b = 1'b1;
    t_regs();
    t_off();
    t_sect();
    t_fault();
    t_page();
    t_flush();
    end_sim();
  end
endmodule : atu_top_test
